// File: logic/aol_top.sv
// offset loop, reduced-rate mode and output pipeline of the sampling converter
// Contract
// - hold clear keeps estimating; hold set freezes estimate but still applies it.
// - four-bit time constant, code 0 is 1M cycles, doubling to 2G at 1011.
// - reduced-rate mode on only for field code 11, off after reset.
// - reduced-rate register reads 00h after reset.
// - each rising clock edge captures a new input sample, except while the output buffer is full.
// - pipelined conversion, one stage per advancing edge, new sample every cycle unless the output buffer is full.
// - output word appears 21 clock cycles after its capture edge.
// - 12-bit words, DDR or parallel mode, offset binary or two's complement.
// - with loop enabled, estimate offset within 10 mV and subtract each cycle.
// - corrected output converges to mid code plus signed four-bit pedestal.
`timescale 1ns/10ps
module aol_top #(
    parameter int LATENCY = aol_pkg::LATENCY_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // ahb-lite register slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // quantiser word from the front end
    input wire logic [aol_pkg::SAMPLE_W-1:0] adc_sample_i,
    output logic sample_take_o,
    // converted sample stream to the receiver
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [aol_pkg::SAMPLE_W-1:0] out_data_o,
    // mode levels to the output and analog sections
    output logic ddr_mode_o,
    output logic low_speed_o
);
    import aol_pkg::*;

    localparam logic signed [ACC_W-1:0] EST_LIM = ACC_W'(RANGE_LSB) <<< FRAC_W;
    localparam logic signed [ACC_W-1:0] OUT_MAX = ACC_W'(MAX_CODE);

    aol_stream_if #(.WIDTH(SAMPLE_W)) st_if ();

    function automatic logic signed [ACC_W-1:0] clip(input logic signed [ACC_W-1:0] v,
        input logic signed [ACC_W-1:0] lo, input logic signed [ACC_W-1:0] hi);
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clip

    ////////////////////////////////////////////////////////////////////////
    // register slave
    logic ap_valid_q, ap_valid_d, ap_write_q, ap_write_d, take;
    logic [7:0] ap_idx_q, ap_idx_d;
    logic [7:0] ped_q, ped_d, ofs_ctrl_q, ofs_ctrl_d, rate_q, rate_d, cfg_q, cfg_d;
    logic [31:0] rdata_q, rdata_d;
    logic signed [ACC_W-1:0] est;
    logic loop_en, hold;

    // zero-wait slave, so the read word is formed in the address phase
    assign take = hsel_i && htrans_i[1] && hready_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_q;

    // writes land in the data phase; reads see them through the _d values
    always_comb begin
        ped_d = ped_q;
        ofs_ctrl_d = ofs_ctrl_q;
        rate_d = rate_q;
        cfg_d = cfg_q;
        if (ap_valid_q && ap_write_q) begin
            unique case (ap_idx_q)
                REG_IDX_PED: ped_d = hwdata_i[7:0] & PED_MASK;
                REG_IDX_OFS_CTRL: ofs_ctrl_d = hwdata_i[7:0] & OFS_CTRL_MASK;
                REG_IDX_RATE: rate_d = hwdata_i[7:0] & RATE_MASK;
                REG_IDX_CFG: cfg_d = hwdata_i[7:0] & CFG_MASK;
                default: ;
            endcase
        end
        ap_valid_d = take;
        ap_idx_d = haddr_i[9:2];
        ap_write_d = hwrite_i;
        rdata_d = rdata_q;
        if (take && !hwrite_i) begin
            unique case (haddr_i[9:2])
                REG_IDX_PED: rdata_d = {24'h000000, ped_d};
                REG_IDX_OFS_CTRL: rdata_d = {24'h000000, ofs_ctrl_d};
                REG_IDX_RATE: rdata_d = {24'h000000, rate_d};
                REG_IDX_CFG: rdata_d = {24'h000000, cfg_d};
                REG_IDX_STAT: rdata_d = {23'h000000, loop_en && !hold, est[7:0]};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // reduced-rate register clears to 00h on reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_idx_q <= 8'h00;
            ped_q <= PED_RST;
            ofs_ctrl_q <= OFS_CTRL_RST;
            rate_q <= RATE_RST;
            cfg_q <= CFG_RST;
            rdata_q <= 32'h00000000;
        end else begin
            ap_valid_q <= ap_valid_d;
            ap_write_q <= ap_write_d;
            ap_idx_q <= ap_idx_d;
            ped_q <= ped_d;
            ofs_ctrl_q <= ofs_ctrl_d;
            rate_q <= rate_d;
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // mode levels; reduced-rate needs both field bits set
    assign low_speed_o = (rate_q[RATE_LSB+:2] == RATE_ON);
    assign ddr_mode_o = cfg_q[CFG_DDR_BIT];
    assign loop_en = cfg_q[CFG_EN_BIT];
    assign hold = ofs_ctrl_q[OFS_HOLD_BIT];

    ////////////////////////////////////////////////////////////////////////
    // conversion pipeline; a full output buffer stalls capture so no word is lost
    logic [SAMPLE_W-1:0] pipe_q [LATENCY];
    logic [SAMPLE_W-1:0] pipe_d [LATENCY];
    logic [LATENCY-1:0] vld_q, vld_d;
    logic adv;
    logic [SAMPLE_W-1:0] raw;

    assign adv = st_if.ready;
    assign sample_take_o = adv;
    assign raw = pipe_q[LATENCY-1];

    // every advancing edge takes a sample and moves each stage by one
    always_comb begin
        pipe_d = pipe_q;
        vld_d = vld_q;
        if (adv) begin
            pipe_d[0] = adc_sample_i;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_d[i] = pipe_q[i-1];
            end
            vld_d = {vld_q[LATENCY-2:0], 1'b1};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_q[i] <= '0;
            end
            vld_q <= '0;
        end else begin
            pipe_q <= pipe_d;
            vld_q <= vld_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // offset estimator: first-order loop, fixed point with FRAC_W fraction bits
    logic signed [ACC_W-1:0] acc_q, acc_d, err_x, corr, word_x;
    logic [3:0] tc_eff;
    logic [5:0] shift;
    logic [SAMPLE_W-1:0] word;

    // reserved codes fall back to the longest defined constant
    always_comb begin
        tc_eff = ofs_ctrl_q[TC_LSB+:4];
        if (tc_eff > TC_MAX) begin
            tc_eff = TC_MAX;
        end
        shift = TC_BASE_SHIFT + {2'b00, tc_eff};
    end

    // error against mid code plus pedestal, so the loop settles there
    assign err_x = ACC_W'($signed({1'b0, raw})) - ACC_W'($signed({1'b0, MID_CODE}))
        - ACC_W'($signed(ped_q[PED_LSB+:4]));
    assign est = acc_q >>> FRAC_W;

    always_comb begin
        acc_d = acc_q;
        if (!loop_en) begin
            acc_d = '0;
        end else if (!hold && adv && vld_q[LATENCY-1]) begin
            acc_d = clip(acc_q + (((err_x <<< FRAC_W) - acc_q) >>> shift),
                -EST_LIM, EST_LIM);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // estimate is applied every cycle, frozen or not; saturate to the code range
    always_comb begin
        corr = ACC_W'($signed({1'b0, raw})) - est;
        word_x = clip(corr, '0, OUT_MAX);
        word = word_x[SAMPLE_W-1:0];
        if (cfg_q[CFG_TWOS_BIT]) begin
            word[SAMPLE_W-1] = ~word[SAMPLE_W-1];
        end
    end

    assign st_if.valid = vld_q[LATENCY-1];
    assign st_if.data = word;

    // buffer adds the last register stage of the latency
    aol_out_buf #(.WIDTH(SAMPLE_W), .DEPTH(2)) u_buf (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_if(st_if.sink),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o(out_data_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // helper state for checks
    logic [4:0] run_q;
    logic first_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_q <= 5'h00;
            first_q <= 1'b0;
        end else begin
            first_q <= 1'b1;
            if (!adv) begin
                run_q <= 5'h00;
            end else if (run_q != 5'h15) begin
                run_q <= run_q + 5'h01;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_hold_freeze: assert property (loop_en && hold |=> $stable(acc_q))
        else $error("estimate moved while held");
    chk_tc_clamp: assert property (shift <= TC_BASE_SHIFT + {2'b00, TC_MAX})
        else $error("loop shift beyond longest time constant");
    chk_rate_mode: assert property ($changed(low_speed_o) |->
        $past(ap_valid_q && ap_write_q && ap_idx_q == REG_IDX_RATE)
        && low_speed_o == ($past(hwdata_i[RATE_LSB+:2]) == RATE_ON))
        else $error("reduced-rate level changed without a matching write");
    chk_rate_reset: assert property (!first_q |-> rate_q == 8'h00)
        else $error("reduced-rate register not 00h after reset");
    chk_capture_edge: assert property (adv |=> pipe_q[0] == $past(adc_sample_i))
        else $error("sample not captured on advancing edge");
    chk_pipe_latency: assert property (run_q == 5'h15 && adv |=>
        st_if.valid && raw == $past(adc_sample_i, 21))
        else $error("sample did not reach last stage after 21 edges");
    chk_loop_off: assert property (!loop_en |=>
        est == '0 && st_if.data[10:0] == raw[10:0])
        else $error("correction applied while loop disabled");
    chk_est_range: assert property (
        est >= -ACC_W'(RANGE_LSB) && est <= ACC_W'(RANGE_LSB))
        else $error("estimate outside correctable range");

    cov_hold: cover property (loop_en && hold && st_if.valid);
    cov_low_speed: cover property (low_speed_o);
    cov_stall: cover property (st_if.valid && !adv);
endmodule : aol_top

// File: logic/aol_pkg.sv
// constants shared by the offset loop converter control block
package aol_pkg;
    // word and pipeline geometry
    localparam int SAMPLE_W = 12;
    localparam int LATENCY_CYC = 21;
    localparam logic [11:0] MID_CODE = 12'h800;
    localparam logic [11:0] MAX_CODE = 12'hFFF;
    // register indices; byte address is four times the index
    localparam logic [7:0] REG_IDX_PED = 8'hBF;
    localparam logic [7:0] REG_IDX_OFS_CTRL = 8'hCF;
    localparam logic [7:0] REG_IDX_RATE = 8'hDF;
    localparam logic [7:0] REG_IDX_CFG = 8'hE0;
    localparam logic [7:0] REG_IDX_STAT = 8'hE1;
    // reset values
    localparam logic [7:0] PED_RST = 8'h00;
    localparam logic [7:0] OFS_CTRL_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    // writable bit masks, everything else reads zero
    localparam logic [7:0] PED_MASK = 8'hF0;
    localparam logic [7:0] OFS_CTRL_MASK = 8'hBC;
    localparam logic [7:0] RATE_MASK = 8'h30;
    localparam logic [7:0] CFG_MASK = 8'h07;
    // field positions
    localparam int OFS_HOLD_BIT = 7;
    localparam int TC_LSB = 2;
    localparam int RATE_LSB = 4;
    localparam int PED_LSB = 4;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_TWOS_BIT = 1;
    localparam int CFG_DDR_BIT = 2;
    // field codes
    localparam logic [3:0] TC_MAX = 4'hB;
    localparam logic [1:0] RATE_ON = 2'h3;
    // loop time constant: code 0 is 2**20 cycles, each code doubles
    localparam logic [5:0] TC_BASE_SHIFT = 6'h14;
    // estimator arithmetic
    localparam int FRAC_W = 32;
    localparam int ACC_W = 46;
    localparam int OFS_RANGE_MV = 10;
    localparam int FULL_SCALE_MV = 1500;
    localparam int RANGE_LSB = (OFS_RANGE_MV * (1 << SAMPLE_W)) / FULL_SCALE_MV;
endpackage : aol_pkg

// File: logic/aol_stream_if.sv
// sample stream carrier between the converter core and its output buffer
`timescale 1ns/10ps
interface aol_stream_if #(
    parameter int WIDTH = 12
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : aol_stream_if

// File: logic/aol_out_buf.sv
// two-entry output buffer with valid and ready on both sides
`timescale 1ns/10ps
module aol_out_buf #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // filling side
    aol_stream_if.sink in_if,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_next

    ////////////////////////////////////////////////////////////////////////
    // handshakes: full stalls the source, empty hides the output
    assign in_if.ready = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_valid_o && out_ready_i;

    // next state of storage and pointers
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_if.data;
            wr_d = ptr_next(wr_q);
        end
        if (pop) begin
            rd_d = ptr_next(rd_q);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a stalled word must neither change nor vanish
    chk_buf_hold_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("buffered word changed while stalled");
    chk_buf_full_stall: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cnt_q == CW'(DEPTH) && !out_ready_i |=> !in_if.ready)
        else $error("full buffer still accepts words");
    cov_buf_full: cover property (@(posedge clk_i) disable iff (!resetn_i)
        !in_if.ready);
endmodule : aol_out_buf

// File: verification/aol_rx_model.sv
// receiver model that takes words off the stream, promptly or with stalls
`timescale 1ns/10ps
module aol_rx_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // stream from the block
    input wire logic valid_i,
    output logic ready_o,
    // pace control from the bench
    input wire logic slow_i
);
    logic [1:0] pace_q;
    ////////////////////////////////////////////////////////////////////////////
    // a slow receiver is ready one cycle in four, so the buffer must fill up
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pace_q <= 2'h0;
            ready_o <= 1'b0;
        end else begin
            pace_q <= pace_q + 2'h1;
            // an idle stream leaves the receiver ready for the next word
            ready_o <= !slow_i || (pace_q == 2'h3) || !valid_i;
        end
    end
endmodule : aol_rx_model

// File: verification/tb.sv
// self-checking bench for the offset loop and rate mode block
`timescale 1ns/10ps
module tb;
    import aol_pkg::*;
    logic clk_i, resetn_i, hsel_i, hwrite_i, out_ready_i, slow, loop_on, twos_on;
    logic hreadyout_o, hresp_o, sample_take_o, out_valid_o, ddr_mode_o, low_speed_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [SAMPLE_W-1:0] adc_sample_i, out_data_o, w;
    logic [7:0] est;
    int bad_count, n_tests, cyc, c, mode_cyc, stall_cyc, n_got, n_refused;
    logic [SAMPLE_W-1:0] q_raw[$];
    int q_cyc[$];

    aol_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .adc_sample_i(adc_sample_i), .sample_take_o(sample_take_o),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
        .ddr_mode_o(ddr_mode_o), .low_speed_o(low_speed_o));
    aol_rx_model u_rx (.clk_i(clk_i), .resetn_i(resetn_i), .valid_i(out_valid_o),
        .ready_o(out_ready_i), .slow_i(slow));

    ////////////////////////////////////////////////////////////////////////////
    task complete_run;
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one single ahb-lite transfer; read data lands in rd
    task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        haddr_i <= {22'h0, idx, 2'h0};
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        chk({31'h0, hresp_o}, 32'h0);
        // let the data-phase edge settle so callers see the new register state
        @(negedge clk_i);
    endtask : bus

    // config write; words caught mid-change are left out of data compares
    task cfg(input logic [7:0] v);
        bus(1'b1, REG_IDX_CFG, {24'h0, v});
        loop_on = v[CFG_EN_BIT];
        twos_on = v[CFG_TWOS_BIT];
        mode_cyc = cyc;
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////
    // capture and accept tracking; every word leaving is matched in order, its data compared only with the loop off
    always @(posedge clk_i) begin
        cyc++;
        if (resetn_i === 1'b1) begin
            if (sample_take_o === 1'b1) begin
                q_raw.push_back(adc_sample_i);
                q_cyc.push_back(cyc);
            end else begin
                n_refused++;
                stall_cyc = cyc;
            end
            if (out_valid_o === 1'b1 && out_ready_i !== 1'b1) stall_cyc = cyc;
            if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
                if (q_raw.size() == 0) begin
                    chk(32'h0, 32'h1);
                end else begin
                    w = q_raw.pop_front();
                    c = q_cyc.pop_front();
                    n_got++;
                    if (stall_cyc < c) chk(32'(cyc - c), 32'(LATENCY_CYC + 1));
                    if (!loop_on && c > mode_cyc + 2) begin
                        chk({20'h0, out_data_o}, {20'h0, twos_on ? w ^ MID_CODE : w});
                    end
                end
            end
        end
        adc_sample_i <= adc_sample_i + 12'h123;
    end

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk({31'h0, low_speed_o}, 32'h0);
        bus(1'b0, REG_IDX_RATE, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, REG_IDX_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset

    // every reduced-rate code, then code 11 again and back to 00
    task t_rate;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, REG_IDX_RATE, 32'(k) << 4);
            bus(1'b0, REG_IDX_RATE, 32'h0);
            chk(rd, 32'(k) << 4);
            chk({31'h0, low_speed_o}, {31'h0, k == 3});
        end
        bus(1'b1, REG_IDX_RATE, 32'h30);
        bus(1'b0, REG_IDX_RATE, 32'h0);
        chk(rd, 32'h30);
        chk({31'h0, low_speed_o}, 32'h1);
        bus(1'b1, REG_IDX_RATE, 32'h0);
        chk({31'h0, low_speed_o}, 32'h0);
    endtask : t_rate

    // both codings and both output modes on a free-running stream
    task t_stream;
        cfg(8'h00);
        repeat (100) @(posedge clk_i);
        chk({31'h0, n_got > 50}, 32'h1);
        cfg(8'h02);
        repeat (100) @(posedge clk_i);
        cfg(8'h06);
        chk({31'h0, ddr_mode_o}, 32'h1);
        repeat (60) @(posedge clk_i);
        cfg(8'h00);
        chk({31'h0, ddr_mode_o}, 32'h0);
        repeat (60) @(posedge clk_i);
    endtask : t_stream

    // stalling receiver: buffer fills, input is refused, no word is lost
    task t_stall;
        slow <= 1'b1;
        repeat (200) @(posedge clk_i);
        chk({31'h0, n_refused > 100}, 32'h1);
        slow <= 1'b0;
        repeat (60) @(posedge clk_i);
        chk({31'h0, q_raw.size() <= LATENCY_CYC + 3}, 32'h1);
    endtask : t_stall

    // time constant codes, estimator run, hold and disable
    task t_ofs;
        bus(1'b1, REG_IDX_PED, 32'h80);
        bus(1'b0, REG_IDX_PED, 32'h0);
        chk(rd, 32'h80);
        bus(1'b1, REG_IDX_PED, 32'h0);
        for (int k = 0; k < 12; k++) begin
            bus(1'b1, REG_IDX_OFS_CTRL, 32'(k) << 2);
            bus(1'b0, REG_IDX_OFS_CTRL, 32'h0);
            chk(rd, 32'(k) << 2);
        end
        cfg(8'h01);
        repeat (40) @(posedge clk_i);
        bus(1'b0, REG_IDX_STAT, 32'h0);
        chk({31'h0, rd[8]}, 32'h1);
        bus(1'b1, REG_IDX_OFS_CTRL, 32'h80);
        bus(1'b0, REG_IDX_STAT, 32'h0);
        chk({31'h0, rd[8]}, 32'h0);
        est = rd[7:0];
        repeat (50) @(posedge clk_i);
        bus(1'b0, REG_IDX_STAT, 32'h0);
        chk({24'h0, rd[7:0]}, {24'h0, est});
        cfg(8'h00);
        bus(1'b0, REG_IDX_STAT, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h0);
        repeat (60) @(posedge clk_i);
    endtask : t_ofs

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        resetn_i = 1'b0;
        hsel_i = 1'b0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        haddr_i = 32'h0;
        hwdata_i = 32'h0;
        adc_sample_i = 12'h000;
        slow = 1'b0;
        loop_on = 1'b0;
        twos_on = 1'b0;
        {bad_count, n_tests, cyc, mode_cyc, stall_cyc, n_got, n_refused} = '0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset;
        t_rate;
        t_stream;
        t_stall;
        t_ofs;
        complete_run;
    end

    // watchdog at 20000 cycles, well past the under one thousand cycles the scenarios need
    initial begin
        #200000;
        bad_count++;
        complete_run;
    end
endmodule : tb
